// file: logic/scc_codec.sv
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_codec (
	// APB slave.
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Transmit character port.
	input  wire logic                          tx_valid,
	input  wire logic [7:0]                    tx_char,
	input  wire logic                          tx_char_type,
	input  wire logic                          violation_send,
	output logic      [9:0]                    tx_code,
	// Receive character port.
	input  wire logic                          rx_code_valid,
	input  wire logic [9:0]                    rx_code,
	output logic      [7:0]                    rx_char,
	output scc_pkg::scc_rx_status_type         rx_char_status,
	output logic                               rx_char_valid,
	// Interrupt.
	output logic                               irq
);
	import scc_pkg::*;

	// ----------------------------------------------------------------------
	// Code tables.
	// ----------------------------------------------------------------------
	localparam logic [5:0] ENC6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] ENC4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] K28_4 [8] = '{
		4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
	localparam logic [7:0] KLIST [`SCC_K_NUM] = '{
		8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
		8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
	localparam logic [4:0] ALT7_NEG_A = 5'h11;
	localparam logic [4:0] ALT7_NEG_B = 5'h12;
	localparam logic [4:0] ALT7_NEG_C = 5'h14;
	localparam logic [4:0] ALT7_POS_A = 5'h0B;
	localparam logic [4:0] ALT7_POS_B = 5'h0D;
	localparam logic [4:0] ALT7_POS_C = 5'h0E;
	localparam logic [4:0] X_D7       = 5'h07;
	localparam logic [2:0] Y_D3       = 3'h3;
	localparam logic [2:0] Y_D7       = 3'h7;

	// ----------------------------------------------------------------------
	// Encoding functions.
	// ----------------------------------------------------------------------
	function automatic logic rd_after6(input logic [5:0] s, input logic rd);
		logic [2:0] n;
		n = 3'($countones(s));
		if (n == 3'd4) begin
			return 1'b1;
		end else if (n == 3'd2) begin
			return 1'b0;
		end
		return rd;
	endfunction : rd_after6

	function automatic logic rd_after(input logic [9:0] c, input logic rd);
		logic [3:0] n;
		n = 4'($countones(c));
		if (n == 4'd6) begin
			return 1'b1;
		end else if (n == 4'd4) begin
			return 1'b0;
		end
		return rd;
	endfunction : rd_after

	function automatic logic [5:0] enc6(input logic [4:0] x, input logic rd);
		logic [5:0] s;
		s = ENC6[x];
		if (rd && ($countones(s) != 3 || x == X_D7)) begin
			s = ~s;
		end
		return s;
	endfunction : enc6

	function automatic logic [9:0] enc_data(input logic [7:0] b, input logic rd);
		logic [5:0] s6;
		logic       r6;
		logic [3:0] s4;
		s6 = enc6(b[4:0], rd);
		r6 = rd_after6(s6, rd);
		s4 = ENC4[b[7:5]];
		if (b[7:5] == Y_D7 && ((!r6 && (b[4:0] == ALT7_NEG_A || b[4:0] == ALT7_NEG_B
		    || b[4:0] == ALT7_NEG_C)) || (r6 && (b[4:0] == ALT7_POS_A
		    || b[4:0] == ALT7_POS_B || b[4:0] == ALT7_POS_C)))) begin
			s4 = `SCC_K7_POS;
		end
		if (r6 && ($countones(s4) != 2 || b[7:5] == Y_D3)) begin
			s4 = ~s4;
		end
		return {s6, s4};
	endfunction : enc_data

	function automatic logic [9:0] enc_k(input logic [7:0] k, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		if (k[4:0] == `SCC_K28_X) begin
			s6 = rd ? `SCC_K6_POS : `SCC_K6_NEG;
			s4 = rd ? ~K28_4[k[7:5]] : K28_4[k[7:5]];
		end else begin
			s6 = enc6(k[4:0], rd);
			s4 = rd ? `SCC_K7_POS : `SCC_K7_NEG;
		end
		return {s6, s4};
	endfunction : enc_k

	// ----------------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------------
	logic                   framer_enable_reg;
	logic [1:0]             decode_table_select_reg;
	logic [`SCC_INT_W-1:0]  int_stat_reg;
	logic [`SCC_INT_W-1:0]  int_mask_reg;
	logic [`SCC_INT_W-1:0]  int_stat_next;
	logic [`SCC_INT_W-1:0]  events;
	logic                   tx_rd_reg;
	logic                   rx_rd_reg;
	logic                   patch_pending_reg;
	logic                   aligned_reg;
	logic [9:0]             tx_code_next;
	logic                   tx_patch_next;
	logic                   tx_rsvd;
	logic [7:0]             rx_char_next;
	scc_rx_status_type      rx_status_next;
	logic                   rx_comma;
	logic                   apb_access;
	logic                   apb_wr;
	logic                   apb_map;
	logic [31:0]            rd_word;

	// ----------------------------------------------------------------------
	// Transmit path.
	// ----------------------------------------------------------------------
	always_comb begin
		scc_tx_kind_type kind;
		logic [7:0]      kbyte;
		logic [7:0]      b;
		kind  = SCC_TX_DATA;
		kbyte = KLIST[5];
		b     = tx_char;
		tx_rsvd       = 1'b0;
		tx_patch_next = 1'b0;
		if (tx_char_type) begin
			kind = SCC_TX_RSVD;
			if (tx_char <= `SCC_SC_PRI_LAST) begin
				kind  = SCC_TX_KCHAR;
				kbyte = KLIST[tx_char[3:0]];
			end else if (tx_char == `SCC_SC_EOF) begin
				kind = SCC_TX_EOF;
			end else if (tx_char == `SCC_SC_VIOL) begin
				kind = SCC_TX_VIOL;
			end else if (tx_char == `SCC_SC_NEGK) begin
				kind = SCC_TX_NEGK;
			end else if (tx_char == `SCC_SC_POSK) begin
				kind = SCC_TX_POSK;
			end else if (tx_char == `SCC_SC_RDVIOL) begin
				kind = SCC_TX_RDVIOL;
			end else begin
				for (int i = 0; i < `SCC_K_NUM; i++) begin
					if (tx_char == KLIST[i]) begin
						kind  = SCC_TX_KCHAR;
						kbyte = tx_char;
					end
				end
			end
		end
		if (!tx_valid) begin
			tx_code_next = tx_rd_reg ? `SCC_K285_POS : `SCC_K285_NEG;
		end else if (violation_send) begin
			tx_code_next = tx_rd_reg ? `SCC_VIOL_POS : `SCC_VIOL_NEG;
		end else begin
			case (kind)
				SCC_TX_DATA: begin
					if (patch_pending_reg) begin
						b[`SCC_F_BIT] = ~tx_rd_reg;
					end
					tx_code_next = enc_data(b, tx_rd_reg);
				end
				SCC_TX_KCHAR: begin
					tx_code_next = enc_k(kbyte, tx_rd_reg);
				end
				SCC_TX_EOF: begin
					tx_code_next  = tx_rd_reg ? `SCC_K285_POS : `SCC_K285_NEG;
					tx_patch_next = 1'b1;
				end
				SCC_TX_VIOL: begin
					tx_code_next = tx_rd_reg ? `SCC_VIOL_POS : `SCC_VIOL_NEG;
				end
				SCC_TX_NEGK: begin
					tx_code_next = `SCC_K285_NEG;
				end
				SCC_TX_POSK: begin
					tx_code_next = `SCC_K285_POS;
				end
				SCC_TX_RDVIOL: begin
					tx_code_next = tx_rd_reg ? `SCC_RDV_POS : `SCC_RDV_NEG;
				end
				default: begin
					tx_code_next = tx_rd_reg ? `SCC_VIOL_POS : `SCC_VIOL_NEG;
					tx_rsvd      = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_code           <= `SCC_K285_NEG;
			tx_rd_reg         <= 1'b0;
			patch_pending_reg <= 1'b0;
		end else begin
			tx_code           <= tx_code_next;
			tx_rd_reg         <= rd_after(tx_code_next, tx_rd_reg);
			patch_pending_reg <= tx_patch_next;
		end
	end

	// ----------------------------------------------------------------------
	// Receive path.
	// ----------------------------------------------------------------------
	always_comb begin
		logic       alt;
		logic       hit;
		logic       bad;
		logic [3:0] kn;
		alt = (decode_table_select_reg != `SCC_SEL_PRIMARY);
		hit = 1'b0;
		bad = 1'b0;
		kn  = 4'h0;
		rx_char_next   = `SCC_SC_VIOL;
		rx_status_next = SCC_RX_VIOL;
		rx_comma       = 1'b0;
		if (rx_code == `SCC_K285_NEG || rx_code == `SCC_K285_POS) begin
			rx_comma       = 1'b1;
			rx_status_next = SCC_RX_SPECIAL;
			rx_char_next   = alt ? KLIST[5] : `SCC_SC_K285_PRI;
			if (rx_code == `SCC_K285_NEG && rx_rd_reg) begin
				rx_char_next = `SCC_SC_NEGK;
			end else if (rx_code == `SCC_K285_POS && !rx_rd_reg) begin
				rx_char_next = `SCC_SC_POSK;
			end
		end else begin
			for (int i = 0; i < 256; i++) begin
				if (enc_data(8'(i), rx_rd_reg) == rx_code) begin
					hit          = 1'b1;
					rx_char_next = 8'(i);
				end else if (enc_data(8'(i), ~rx_rd_reg) == rx_code) begin
					bad = 1'b1;
				end
			end
			for (int k = 0; k < `SCC_K_NUM; k++) begin
				if (enc_k(KLIST[k], rx_rd_reg) == rx_code) begin
					hit          = 1'b1;
					kn           = 4'(k);
					rx_char_next = alt ? KLIST[k] : {4'h0, 4'(k)};
				end else if (enc_k(KLIST[k], ~rx_rd_reg) == rx_code) begin
					bad = 1'b1;
				end
			end
			if (hit) begin
				rx_status_next = (kn != 4'h0 || rx_code[9:4] == `SCC_K6_NEG
				    || rx_code[9:4] == `SCC_K6_POS || rx_code[3:0] == `SCC_K7_NEG
				    && enc_k(KLIST[kn], rx_rd_reg) == rx_code)
				    ? SCC_RX_SPECIAL : SCC_RX_DATA;
			end else if (bad) begin
				rx_char_next   = `SCC_SC_RDVIOL;
				rx_status_next = SCC_RX_DISP;
			end else begin
				rx_char_next   = `SCC_SC_VIOL;
				rx_status_next = SCC_RX_VIOL;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_char        <= 8'h00;
			rx_char_status <= SCC_RX_DATA;
			rx_char_valid  <= 1'b0;
			rx_rd_reg      <= 1'b0;
		end else begin
			rx_char_valid <= rx_code_valid;
			if (rx_code_valid) begin
				rx_char        <= rx_char_next;
				rx_char_status <= rx_status_next;
				rx_rd_reg      <= rd_after(rx_code, rx_rd_reg);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aligned_reg <= 1'b0;
		end else if (!framer_enable_reg) begin
			aligned_reg <= 1'b0;
		end else if (rx_code_valid && rx_comma) begin
			aligned_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// APB slave and interrupts.
	// ----------------------------------------------------------------------
	assign apb_access = psel && penable && !pready;
	assign apb_wr     = apb_access && pwrite;
	assign apb_map    = (paddr == `SCC_CTRL_OFF) || (paddr == `SCC_STAT_OFF)
	    || (paddr == `SCC_INT_STAT_OFF) || (paddr == `SCC_INT_MASK_OFF);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (paddr == `SCC_CTRL_OFF) begin
			rd_word[`SCC_CTRL_FRAMER] = framer_enable_reg;
			rd_word[`SCC_CTRL_SEL_HI:`SCC_CTRL_SEL_LO] = decode_table_select_reg;
		end else if (paddr == `SCC_STAT_OFF) begin
			rd_word[`SCC_STAT_ALIGNED] = aligned_reg;
			rd_word[`SCC_STAT_TX_RD]   = tx_rd_reg;
			rd_word[`SCC_STAT_RX_RD]   = rx_rd_reg;
		end else if (paddr == `SCC_INT_STAT_OFF) begin
			rd_word[`SCC_INT_W-1:0] = int_stat_reg;
		end else if (paddr == `SCC_INT_MASK_OFF) begin
			rd_word[`SCC_INT_W-1:0] = int_mask_reg;
		end
	end

	always_comb begin
		events = '0;
		events[`SCC_EV_RX_VIOL]  = rx_code_valid && !rx_comma && rx_status_next == SCC_RX_VIOL;
		events[`SCC_EV_RX_DISP]  = rx_code_valid && rx_status_next == SCC_RX_DISP;
		events[`SCC_EV_RX_COMMA] = rx_code_valid && rx_comma;
		events[`SCC_EV_TX_RSVD]  = tx_valid && !violation_send && tx_rsvd;
		int_stat_next = int_stat_reg;
		if (apb_wr && paddr == `SCC_INT_STAT_OFF) begin
			int_stat_next = int_stat_next & ~pwdata[`SCC_INT_W-1:0];
		end
		int_stat_next = int_stat_next | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access && !apb_map;
			prdata  <= (apb_access && !pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framer_enable_reg       <= 1'b0;
			decode_table_select_reg <= `SCC_SEL_PRIMARY;
			int_mask_reg            <= `SCC_INT_RST;
		end else if (apb_wr) begin
			if (paddr == `SCC_CTRL_OFF) begin
				framer_enable_reg       <= pwdata[`SCC_CTRL_FRAMER];
				decode_table_select_reg <= pwdata[`SCC_CTRL_SEL_HI:`SCC_CTRL_SEL_LO];
			end else if (paddr == `SCC_INT_MASK_OFF) begin
				int_mask_reg <= pwdata[`SCC_INT_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_reg <= `SCC_INT_RST;
			irq          <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			irq          <= |(int_stat_next & int_mask_reg);
		end
	end

endmodule : scc_codec

// file: logic/scc_defines.svh
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define SCC_CTRL_OFF      8'h00
`define SCC_STAT_OFF      8'h04
`define SCC_INT_STAT_OFF  8'h08
`define SCC_INT_MASK_OFF  8'h0C

// ----------------------------------------------------------------------
// Register fields and reset values.
// ----------------------------------------------------------------------
`define SCC_CTRL_FRAMER   0
`define SCC_CTRL_SEL_LO   1
`define SCC_CTRL_SEL_HI   2
`define SCC_CTRL_RST      3'h0
`define SCC_STAT_ALIGNED  0
`define SCC_STAT_TX_RD    1
`define SCC_STAT_RX_RD    2
`define SCC_INT_W         4
`define SCC_EV_RX_VIOL    0
`define SCC_EV_RX_DISP    1
`define SCC_EV_RX_COMMA   2
`define SCC_EV_TX_RSVD    3
`define SCC_INT_RST       4'h0
`define SCC_SEL_PRIMARY   2'h0

// ----------------------------------------------------------------------
// Special character byte codes.
// ----------------------------------------------------------------------
`define SCC_SC_EOF        8'h22
`define SCC_SC_VIOL       8'hE0
`define SCC_SC_NEGK       8'hE1
`define SCC_SC_POSK       8'hE2
`define SCC_SC_RDVIOL     8'hE4
`define SCC_SC_K285_PRI   8'h05
`define SCC_SC_PRI_LAST   8'h0B
`define SCC_K_NUM         12
`define SCC_K28_X         5'h1C
`define SCC_F_BIT         5

// ----------------------------------------------------------------------
// Ten-bit transmission characters and six- and four-bit sub-blocks, negative and positive forms.
// ----------------------------------------------------------------------
`define SCC_K285_NEG      10'h0FA
`define SCC_K285_POS      10'h305
`define SCC_VIOL_NEG      10'h278
`define SCC_VIOL_POS      10'h187
`define SCC_RDV_NEG       10'h375
`define SCC_RDV_POS       10'h08A
`define SCC_K7_NEG        4'h8
`define SCC_K7_POS        4'h7
`define SCC_K6_NEG        6'h0F
`define SCC_K6_POS        6'h30

`endif

// file: logic/scc_pkg.sv
package scc_pkg;

	typedef enum logic [2:0] {
		SCC_RX_DATA    = 3'b000,
		SCC_RX_SPECIAL = 3'b001,
		SCC_RX_VIOL    = 3'b101,
		SCC_RX_DISP    = 3'b110
	} scc_rx_status_type;

	typedef enum logic [2:0] {
		SCC_TX_DATA   = 3'b000,
		SCC_TX_KCHAR  = 3'b001,
		SCC_TX_EOF    = 3'b010,
		SCC_TX_VIOL   = 3'b011,
		SCC_TX_NEGK   = 3'b100,
		SCC_TX_POSK   = 3'b101,
		SCC_TX_RDVIOL = 3'b110,
		SCC_TX_RSVD   = 3'b111
	} scc_tx_kind_type;

endpackage : scc_pkg

// file: test/scc_codec_assertions.sv
`timescale 1ns/10ps
`include "scc_defines.svh"
module scc_codec_checker
	import scc_pkg::*;
(
	// Clock and reset.
	input wire logic                   pclk,
	input wire logic                   presetn,
	// Register bus.
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Transmit side.
	input wire logic                   tx_valid,
	input wire logic [7:0]             tx_char,
	input wire logic                   tx_char_type,
	input wire logic                   violation_send,
	input wire logic [9:0]             tx_code,
	// Receive side.
	input wire logic                   rx_code_valid,
	input wire logic [7:0]             rx_char,
	input scc_pkg::scc_rx_status_type  rx_char_status,
	input wire logic                   rx_char_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Named steps.
	// ----------------------------------------------------------------
	sequence s_fill2;
		!tx_valid ##1 !tx_valid;
	endsequence
	sequence s_kcmd(logic [7:0] c);
		tx_valid && tx_char_type && !violation_send && tx_char == c;
	endsequence

	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer missing");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error without ready");
	a_fill_comma: assert property (!tx_valid |=> tx_code inside {`SCC_K285_NEG, `SCC_K285_POS})
		else $error("fill not comma");
	a_fill_flips: assert property (s_fill2 |=> tx_code != $past(tx_code))
		else $error("disparity not tracked");
	a_negk_send: assert property (s_kcmd(`SCC_SC_NEGK) |=> tx_code == `SCC_K285_NEG)
		else $error("negative comma wrong");
	a_posk_send: assert property (s_kcmd(`SCC_SC_POSK) |=> tx_code == `SCC_K285_POS)
		else $error("positive comma wrong");
	a_eof_comma: assert property (s_kcmd(`SCC_SC_EOF) |=> tx_code[8:2] inside {7'h3E, 7'h41})
		else $error("end of frame not comma");
	a_viol_send: assert property (tx_valid && (violation_send || tx_char_type
		&& tx_char == `SCC_SC_VIOL) |=> tx_code inside {`SCC_VIOL_NEG, `SCC_VIOL_POS})
		else $error("violation not sent");
	a_rx_follow: assert property (1'b1 |=> rx_char_valid == $past(rx_code_valid))
		else $error("receive valid misplaced");
	a_rx_no_eof: assert property (rx_char_valid |-> rx_char != `SCC_SC_EOF)
		else $error("end of frame decoded");
	a_rx_viol: assert property (rx_char_valid && rx_char_status == SCC_RX_VIOL |-> rx_char == `SCC_SC_VIOL)
		else $error("violation code wrong");
	a_rx_disp: assert property (rx_char_valid && rx_char_status == SCC_RX_DISP |-> rx_char == `SCC_SC_RDVIOL)
		else $error("disparity code wrong");
endmodule : scc_codec_checker

bind scc_codec scc_codec_checker u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
	.pslverr, .tx_valid, .tx_char, .tx_char_type, .violation_send, .tx_code, .rx_code_valid,
	.rx_char, .rx_char_status, .rx_char_valid);

// file: test/scc_host.sv
`timescale 1ns/10ps
module scc_host (
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// Character lines.
	input wire logic [9:0]  tx_code,
	output logic            rx_code_valid,
	output logic [9:0]      rx_code
);
	logic       loop_en = 1'b0;
	logic       inj_req = 1'b0;
	logic [9:0] inj_code = 10'h000;

	// Loops sent characters back or injects chosen ones; idle lines toggle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_code_valid <= 1'b0;
			rx_code <= 10'h000;
		end else if (loop_en) begin
			rx_code_valid <= 1'b1;
			rx_code <= tx_code;
		end else if (inj_req) begin
			rx_code_valid <= 1'b1;
			rx_code <= inj_code;
		end else begin
			rx_code_valid <= 1'b0;
			rx_code <= ~rx_code;
		end
	end

	task set_loop(input logic on);
		loop_en <= on;
	endtask : set_loop

	task inject(input logic [9:0] a, input logic [9:0] b);
		inj_code <= a;
		inj_req <= 1'b1;
		@(posedge pclk);
		inj_code <= b;
		@(posedge pclk);
		inj_req <= 1'b0;
	endtask : inject
endmodule : scc_host

// file: test/tb_top.sv
`timescale 1ns/10ps
`include "scc_defines.svh"
module tb_top;
	import scc_pkg::*;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              tx_valid;
	logic [7:0]        tx_char;
	logic              tx_char_type;
	logic              violation_send;
	logic [9:0]        tx_code;
	logic              rx_code_valid;
	logic [9:0]        rx_code;
	logic [7:0]        rx_char;
	scc_rx_status_type rx_char_status;
	logic              rx_char_valid;
	logic              irq;
	logic [31:0]       rd;
	logic              err;
	int                error_cnt = 0;
	int                num_checks = 0;
	int                cycles = 0;
	// Row: valid, special, force, byte, sent code, decoded byte, status; 3FF/111 skip.
	localparam logic [31:0] SEQ [18] = '{
		{3'b110, 8'hE1, 10'h0FA, 8'h00, 3'b111}, {3'b110, 8'hE1, 10'h0FA, 8'hE1, 3'b001},
		{3'b000, 8'h00, 10'h305, 8'h05, 3'b001}, {3'b000, 8'h00, 10'h0FA, 8'h05, 3'b001},
		{3'b110, 8'hE2, 10'h305, 8'h05, 3'b001}, {3'b110, 8'hE2, 10'h305, 8'hE2, 3'b001},
		{3'b110, 8'h22, 10'h0FA, 8'h05, 3'b001}, {3'b100, 8'h95, 10'h3FF, 8'h95, 3'b000},
		{3'b000, 8'h00, 10'h0FA, 8'h05, 3'b001}, {3'b110, 8'h22, 10'h305, 8'h05, 3'b001},
		{3'b100, 8'h95, 10'h3FF, 8'hB5, 3'b000}, {3'b110, 8'hE0, 10'h278, 8'hE0, 3'b101},
		{3'b101, 8'h00, 10'h278, 8'hE0, 3'b101}, {3'b110, 8'hE4, 10'h375, 8'h00, 3'b111},
		{3'b110, 8'hBC, 10'h0FA, 8'h05, 3'b001}, {3'b110, 8'h23, 10'h187, 8'hE0, 3'b101},
		{3'b000, 8'h00, 10'h305, 8'h05, 3'b001}, {3'b000, 8'h00, 10'h0FA, 8'h05, 3'b001}};

	scc_codec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .tx_valid, .tx_char, .tx_char_type, .violation_send, .tx_code,
		.rx_code_valid, .rx_code, .rx_char, .rx_char_status, .rx_char_valid, .irq);
	scc_host u_host (.pclk, .presetn, .tx_code, .rx_code_valid, .rx_code);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	task close_out;
		$display("checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(negedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] row(input int i);
		return (i >= 0 && i < 18) ? SEQ[i] : 32'h001FF807;
	endfunction : row

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task t_regs;
		apb(1'b0, `SCC_CTRL_OFF, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		apb(1'b0, `SCC_INT_MASK_OFF, 32'h0);
		chk("mask reset", rd, 32'h0);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		chk("unmapped write err", err, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped read err", err, 1'b1);
		chk("unmapped read", rd, 32'h0);
		apb(1'b1, `SCC_CTRL_OFF, 32'h1);
		apb(1'b0, `SCC_CTRL_OFF, 32'h0);
		chk("ctrl", rd, 32'h1);
	endtask : t_regs

	// Framing is on, so the stream keeps clear of alias comma pairs.
	task t_stream;
		logic [31:0] r;
		u_host.set_loop(1'b1);
		for (int k = 0; k < 21; k++) begin
			r = row(k);
			tx_valid <= r[31];
			tx_char_type <= r[30];
			violation_send <= r[29];
			tx_char <= r[28:21];
			@(negedge pclk);
			r = row(k - 1);
			if (r[20:11] != 10'h3FF) chk("tx_code", tx_code, r[20:11]);
			r = row(k - 3);
			if (r[2:0] != 3'b111) chk("rx", {rx_char_valid, rx_char, rx_char_status}, {1'b1, r[10:0]});
			@(posedge pclk);
		end
	endtask : t_stream

	task t_alt;
		apb(1'b1, `SCC_CTRL_OFF, 32'h3);
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk("alt decode", {rx_char, rx_char_status}, {8'hBC, 3'b001});
		apb(1'b0, `SCC_STAT_OFF, 32'h0);
		chk("aligned", rd[0], 1'b1);
		apb(1'b1, `SCC_CTRL_OFF, 32'h0);
		apb(1'b0, `SCC_STAT_OFF, 32'h0);
		chk("unaligned", rd[0], 1'b0);
	endtask : t_alt

	task t_irq;
		u_host.set_loop(1'b0);
		apb(1'b0, `SCC_INT_STAT_OFF, 32'h0);
		chk("events", rd & 32'hD, 32'hD);
		apb(1'b1, `SCC_INT_STAT_OFF, 32'hF);
		apb(1'b1, `SCC_INT_MASK_OFF, 32'h2);
		apb(1'b0, `SCC_INT_STAT_OFF, 32'h0);
		chk("cleared", rd, 32'h0);
		chk("irq idle", irq, 1'b0);
		u_host.inject(10'h305, 10'h286);
		@(posedge pclk);
		@(negedge pclk);
		chk("disp err", {rx_char, rx_char_status}, {8'hE4, SCC_RX_DISP});
		repeat (2) @(negedge pclk);
		chk("irq set", irq, 1'b1);
		apb(1'b0, `SCC_INT_STAT_OFF, 32'h0);
		chk("disp event", rd, 32'h6);
		apb(1'b1, `SCC_INT_MASK_OFF, 32'h0);
		@(negedge pclk);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, `SCC_INT_MASK_OFF, 32'h2);
		@(negedge pclk);
		chk("irq unmasked", irq, 1'b1);
		apb(1'b1, `SCC_INT_STAT_OFF, 32'h2);
		@(negedge pclk);
		chk("irq cleared", irq, 1'b0);
		apb(1'b0, `SCC_INT_STAT_OFF, 32'h0);
		chk("left events", rd, 32'h4);
	endtask : t_irq

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_valid, tx_char, tx_char_type, violation_send} = '0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_stream();
		t_alt();
		t_irq();
		close_out();
	end
endmodule : tb_top
